// file: logic/bmm_adc_seq.sv
// one-channel integrating conversion handshake
`timescale 1ns/10ps
module bmm_adc_seq (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        srst,
  // request side
  input  wire logic        start,
  output logic             busy,
  output logic             done,
  output logic [15:0]      result,
  // converter side
  output logic             conv_req,
  input  wire logic        conv_ack,
  input  wire logic [15:0] conv_data
);
  typedef struct packed {
    logic        busy;
    logic        done;
    logic [15:0] result;
  } bmm_adc_st_type;

  bmm_adc_st_type st_ff;
  bmm_adc_st_type nxt_st;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.done = 1'b0;
    if (!st_ff.busy && start) begin
      nxt_st.busy = 1'b1;
    end else if (st_ff.busy && conv_ack) begin
      nxt_st.busy = 1'b0;
      nxt_st.done = 1'b1;
      nxt_st.result = conv_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign busy = st_ff.busy;
  assign done = st_ff.done;
  assign result = st_ff.result;
  assign conv_req = st_ff.busy;
endmodule

// file: logic/bmm_consts.svh
// constants for the battery measurement and power mode controller
`ifndef BMM_CONSTS_SVH
`define BMM_CONSTS_SVH
`define BMM_CUR_SCALE_SH    14
`define BMM_CUR_FULL_SCALE  16384
`define BMM_VOLT_SCALE_SH   11
`define BMM_RES_DIV         65535
`define BMM_AZ_TIME_S       30
`define BMM_PERIOD_MS       500
`define BMM_WAKE_IO_BIT     6
`define BMM_WAKE_BUS_BIT    5
`define BMM_WAKE_CUR_BIT    4
`define BMM_WAKE_VOLT_BIT   3
`define BMM_WAKE_LVL_MSB    2
`define BMM_WAKE_RST        8'h00
`define BMM_QUAL_COUNT      2
`endif

// file: logic/bmm_ctrl.sv
// measurement sequencing, calibration and power mode control
`timescale 1ns/10ps
`include "bmm_consts.svh"
module bmm_ctrl #(
  parameter int unsigned AZ_PERIODS = (`BMM_AZ_TIME_S * 1000) / `BMM_PERIOD_MS
) (
  // clock and reset
  input  wire logic                   sys_clk,
  input  wire logic                   srst,
  // time base and parameters
  input  wire logic                   period_tick,
  input  wire bmm_pkg::bmm_param_type prm,
  input  wire logic                   wake_cfg_we,
  input  wire logic [7:0]             wake_cfg_wdata,
  output logic [7:0]                  wake_source_config,
  // converter front end
  output logic                        conv_req,
  output logic [1:0]                  conv_chan,
  output logic                        sense_short,
  input  wire logic                   conv_ack,
  input  wire logic [15:0]            conv_data,
  output logic                        therm_ref_en,
  // wake sources and display
  input  wire logic                   io_activity,
  input  wire logic                   bus_activity,
  input  wire logic                   wake_current_hit,
  input  wire logic                   wake_voltage_hit,
  input  wire logic                   led_display_active,
  // results and status
  output bmm_pkg::bmm_result_type     res,
  output bmm_pkg::bmm_mode_type       mode,
  output logic                        calc_strobe,
  output logic                        eoc_temp_en,
  output logic                        bus_accept,
  output logic                        display_en,
  output logic [2:0]                  wake_voltage_select
);
  localparam logic [1:0] CH_CUR  = 2'h0;
  localparam logic [1:0] CH_VOLT = 2'h1;
  localparam logic [1:0] CH_TINT = 2'h2;
  localparam logic [1:0] CH_TEXT = 2'h3;

  typedef struct packed {
    bmm_pkg::bmm_mode_type  mode;
    bmm_pkg::bmm_phase_type phase;
    logic [7:0]             samp_cnt;
    logic [15:0]            az_cnt;
    logic                   az_cycle;
    logic [15:0]            autozero_offset;
    logic [1:0]             hi_cnt;
    logic [1:0]             lo_cnt;
    logic [7:0]             wake_cfg;
    logic                   calc;
    bmm_pkg::bmm_result_type res;
  } bmm_st_type;

  bmm_st_type st_ff;
  bmm_st_type nxt_st;

  logic        adc_start;
  logic        adc_busy;
  logic        adc_done;
  logic [15:0] adc_result;

  // (raw - offset) * gain >> shift, 16 bit signed result
  function automatic logic signed [15:0] cal(input logic [15:0] raw,
                                             input logic [15:0] off,
                                             input logic [15:0] gain,
                                             input int unsigned sh);
    logic signed [17:0] diff;
    logic signed [34:0] prod;
    diff = 18'(signed'(raw)) - 18'(signed'(off));
    prod = 35'(diff) * 35'(signed'({1'b0, gain}));
    return 16'(prod >>> sh);
  endfunction

  function automatic logic [15:0] mag(input logic signed [15:0] v);
    return v[15] ? 16'(-v) : 16'(v);
  endfunction

  // thermistor divider voltage to temperature, coarse table
  function automatic logic signed [15:0] therm_lut(input logic [15:0] v);
    logic signed [15:0] t;
    case (v[10:8])
      3'h0:    t = 16'sh03e8;
      3'h1:    t = 16'sh02ee;
      3'h2:    t = 16'sh0258;
      3'h3:    t = 16'sh01f4;
      3'h4:    t = 16'sh0190;
      3'h5:    t = 16'sh012c;
      3'h6:    t = 16'sh00c8;
      default: t = 16'sh0064;
    endcase
    return t - 16'(v[7:0]) / 16'h0003;
  endfunction

  logic signed [15:0] cur_cal;
  logic signed [15:0] thr_ma;
  logic signed [15:0] v_cal;
  logic signed [31:0] drop;
  logic signed [15:0] t_cal;
  logic               above_thr;
  logic               below_thr;
  logic               wake_hit;
  logic               conv_period;

  always_comb begin
    cur_cal = cal(adc_result, 16'(prm.current_offset_cal + st_ff.autozero_offset),
                  prm.current_gain_cal, `BMM_CUR_SCALE_SH);
    thr_ma = cal(prm.run_threshold_raw, 16'h0000, prm.current_gain_cal,
                 `BMM_CUR_SCALE_SH);
    v_cal = cal(adc_result, prm.voltage_offset_cal, prm.voltage_gain_cal,
                `BMM_VOLT_SCALE_SH);
    drop = 32'(st_ff.res.current_ma) * 32'(signed'({1'b0, prm.path_resistance}))
           / 32'sd`BMM_RES_DIV;
    if (prm.ext_temp_sel) begin
      t_cal = cal(16'(therm_lut(adc_result)), prm.ext_temp_offset_cal,
                  prm.ext_temp_gain_cal, `BMM_VOLT_SCALE_SH);
    end else begin
      t_cal = cal(adc_result, prm.int_temp_offset_cal, prm.int_temp_gain_cal,
                  `BMM_VOLT_SCALE_SH);
    end
    above_thr = mag(st_ff.res.current_ma) > mag(thr_ma);
    below_thr = mag(st_ff.res.current_ma) < mag(thr_ma);
    wake_hit = (st_ff.wake_cfg[`BMM_WAKE_IO_BIT] && io_activity) ||
               (st_ff.wake_cfg[`BMM_WAKE_BUS_BIT] && bus_activity) ||
               (st_ff.wake_cfg[`BMM_WAKE_CUR_BIT] && wake_current_hit) ||
               (st_ff.wake_cfg[`BMM_WAKE_VOLT_BIT] && wake_voltage_hit);
    conv_period = (st_ff.mode == bmm_pkg::MODE_RUN) ||
                  (st_ff.mode == bmm_pkg::MODE_SAMPLE && st_ff.samp_cnt == 8'h00);
  end

  always_comb begin
    nxt_st = st_ff;
    nxt_st.calc = 1'b0;
    adc_start = 1'b0;
    if (wake_cfg_we) begin
      nxt_st.wake_cfg = wake_cfg_wdata;
    end
    case (st_ff.phase)
      bmm_pkg::PH_IDLE: begin
        if (period_tick && st_ff.mode != bmm_pkg::MODE_SLEEP) begin
          if (st_ff.mode == bmm_pkg::MODE_SAMPLE) begin
            nxt_st.samp_cnt = (st_ff.samp_cnt + 8'h01 >= prm.sample_period_count) ?
                              8'h00 : st_ff.samp_cnt + 8'h01;
          end
          if (prm.autozero_en) begin
            nxt_st.az_cnt = (32'(st_ff.az_cnt) + 1 >= AZ_PERIODS) ?
                            16'h0000 : st_ff.az_cnt + 16'h0001;
          end
          nxt_st.az_cycle = prm.autozero_en && (32'(st_ff.az_cnt) + 1 >= AZ_PERIODS);
          if (conv_period) begin
            nxt_st.phase = bmm_pkg::PH_CUR;
            adc_start = 1'b1;
          end else begin
            nxt_st.phase = bmm_pkg::PH_CALC;
          end
        end
      end
      bmm_pkg::PH_CUR: begin
        if (adc_done) begin
          if (st_ff.az_cycle) begin
            nxt_st.autozero_offset = adc_result;
          end else if (mag(cur_cal) < prm.zero_zone_limit) begin
            nxt_st.res.current_ma = 16'sh0000;
            nxt_st.res.current_valid = 1'b0;
          end else begin
            nxt_st.res.current_ma = cur_cal;
            nxt_st.res.current_valid = 1'b1;
          end
          nxt_st.phase = bmm_pkg::PH_VOLT;
          adc_start = 1'b1;
        end
      end
      bmm_pkg::PH_VOLT: begin
        if (adc_done) begin
          nxt_st.res.voltage_mv = 16'(32'(v_cal) + drop);
          nxt_st.phase = bmm_pkg::PH_TEMP;
          adc_start = 1'b1;
        end
      end
      bmm_pkg::PH_TEMP: begin
        if (adc_done) begin
          nxt_st.res.temp_val = t_cal;
          nxt_st.phase = bmm_pkg::PH_CALC;
          nxt_st.hi_cnt = above_thr ? ((st_ff.hi_cnt == 2'h2) ? 2'h2 : st_ff.hi_cnt + 2'h1)
                                    : 2'h0;
          nxt_st.lo_cnt = below_thr ? ((st_ff.lo_cnt == 2'h2) ? 2'h2 : st_ff.lo_cnt + 2'h1)
                                    : 2'h0;
        end
      end
      bmm_pkg::PH_CALC: begin
        nxt_st.calc = 1'b1;
        nxt_st.phase = bmm_pkg::PH_IDLE;
        case (st_ff.mode)
          bmm_pkg::MODE_RUN: begin
            if (st_ff.lo_cnt >= 2'(`BMM_QUAL_COUNT)) begin
              nxt_st.mode = bmm_pkg::MODE_SAMPLE;
              nxt_st.lo_cnt = 2'h0;
              nxt_st.samp_cnt = 8'h00;
            end
          end
          bmm_pkg::MODE_SAMPLE: begin
            if (st_ff.hi_cnt >= 2'(`BMM_QUAL_COUNT)) begin
              nxt_st.mode = bmm_pkg::MODE_RUN;
              nxt_st.hi_cnt = 2'h0;
            end else if (st_ff.res.voltage_mv < prm.sleep_voltage_limit) begin
              nxt_st.mode = bmm_pkg::MODE_SLEEP;
            end
          end
          default: begin
            nxt_st.mode = st_ff.mode;
          end
        endcase
      end
      default: begin
        nxt_st.phase = bmm_pkg::PH_IDLE;
      end
    endcase
    if (st_ff.mode == bmm_pkg::MODE_SLEEP && wake_hit) begin
      nxt_st.mode = bmm_pkg::MODE_RUN;
      nxt_st.hi_cnt = 2'h0;
      nxt_st.lo_cnt = 2'h0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st_ff <= '0;
      st_ff.wake_cfg <= `BMM_WAKE_RST;
      st_ff.mode <= bmm_pkg::MODE_SAMPLE;
      st_ff.phase <= bmm_pkg::PH_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  bmm_adc_seq u_adc (
    .sys_clk   (sys_clk),
    .srst      (srst),
    .start     (adc_start),
    .busy      (adc_busy),
    .done      (adc_done),
    .result    (adc_result),
    .conv_req  (conv_req),
    .conv_ack  (conv_ack),
    .conv_data (conv_data)
  );

  always_comb begin
    case (st_ff.phase)
      bmm_pkg::PH_VOLT: conv_chan = CH_VOLT;
      bmm_pkg::PH_TEMP: conv_chan = prm.ext_temp_sel ? CH_TEXT : CH_TINT;
      default:          conv_chan = CH_CUR;
    endcase
  end

  assign sense_short = st_ff.az_cycle && st_ff.phase == bmm_pkg::PH_CUR;
  assign therm_ref_en = prm.ext_temp_sel && st_ff.phase == bmm_pkg::PH_TEMP;
  assign res = st_ff.res;
  assign mode = st_ff.mode;
  assign calc_strobe = st_ff.calc;
  assign wake_source_config = st_ff.wake_cfg;
  assign wake_voltage_select = st_ff.wake_cfg[`BMM_WAKE_LVL_MSB:0];
  assign eoc_temp_en = !led_display_active && st_ff.mode != bmm_pkg::MODE_SLEEP;
  assign bus_accept = st_ff.mode != bmm_pkg::MODE_SLEEP;
  assign display_en = st_ff.mode != bmm_pkg::MODE_SLEEP;

  // assertions
  property p_sleep_from_sample;
    @(posedge sys_clk) disable iff (srst)
    (mode == bmm_pkg::MODE_SLEEP && $past(mode) != bmm_pkg::MODE_SLEEP)
      |-> $past(mode) == bmm_pkg::MODE_SAMPLE;
  endproperty
  a_sleep_from_sample: assert property (p_sleep_from_sample)
    else $error("sleep entered from non-sample mode");

  property p_run_not_sleep;
    @(posedge sys_clk) disable iff (srst)
    mode == bmm_pkg::MODE_RUN |=> mode != bmm_pkg::MODE_SLEEP;
  endproperty
  a_run_not_sleep: assert property (p_run_not_sleep)
    else $error("run went straight to sleep");

  property p_sleep_exit_run;
    @(posedge sys_clk) disable iff (srst)
    (mode == bmm_pkg::MODE_SLEEP) ##1 (mode != bmm_pkg::MODE_SLEEP)
      |-> mode == bmm_pkg::MODE_RUN && $past(wake_hit);
  endproperty
  a_sleep_exit_run: assert property (p_sleep_exit_run)
    else $error("sleep left without wake or not to run");

  property p_no_conv_sleep;
    @(posedge sys_clk) disable iff (srst)
    mode == bmm_pkg::MODE_SLEEP && $past(mode) == bmm_pkg::MODE_SLEEP |-> !adc_start;
  endproperty
  a_no_conv_sleep: assert property (p_no_conv_sleep)
    else $error("conversion started while asleep");

  property p_eoc_led;
    @(posedge sys_clk) disable iff (srst)
    led_display_active |-> !eoc_temp_en;
  endproperty
  a_eoc_led: assert property (p_eoc_led)
    else $error("end-of-charge temperature active during display");

  property p_zero_zone;
    @(posedge sys_clk) disable iff (srst)
    res.current_ma != 16'sh0000 |-> mag(res.current_ma) >= prm.zero_zone_limit
      || $stable(res.current_ma);
  endproperty
  a_zero_zone: assert property (p_zero_zone)
    else $error("current inside zero zone not forced to zero");

  property p_az_keep;
    @(posedge sys_clk) disable iff (srst)
    (st_ff.phase == bmm_pkg::PH_CUR && adc_done && st_ff.az_cycle)
      |=> $stable(res.current_ma);
  endproperty
  a_az_keep: assert property (p_az_keep)
    else $error("auto-zero period changed the current result");

  property p_run_to_sample;
    @(posedge sys_clk) disable iff (srst)
    (mode == bmm_pkg::MODE_RUN) ##1 (mode == bmm_pkg::MODE_SAMPLE)
      |-> $past(st_ff.lo_cnt) == 2'h2;
  endproperty
  a_run_to_sample: assert property (p_run_to_sample)
    else $error("run left without two low results");

  property p_bus_sleep;
    @(posedge sys_clk) disable iff (srst)
    mode == bmm_pkg::MODE_SLEEP |-> !bus_accept && !display_en;
  endproperty
  a_bus_sleep: assert property (p_bus_sleep)
    else $error("bus or display active in sleep");

  property p_start_idle;
    @(posedge sys_clk) disable iff (srst)
    adc_start |-> !adc_busy;
  endproperty
  a_start_idle: assert property (p_start_idle)
    else $error("conversion started while converter busy");

  c_enter_run: cover property (@(posedge sys_clk) disable iff (srst)
    $past(mode) == bmm_pkg::MODE_SAMPLE && mode == bmm_pkg::MODE_RUN);
  c_enter_sleep: cover property (@(posedge sys_clk) disable iff (srst)
    mode == bmm_pkg::MODE_SLEEP);
  c_wake: cover property (@(posedge sys_clk) disable iff (srst)
    $past(mode) == bmm_pkg::MODE_SLEEP && mode == bmm_pkg::MODE_RUN);
  c_autozero: cover property (@(posedge sys_clk) disable iff (srst)
    sense_short && conv_ack);
endmodule

// file: logic/bmm_pkg.sv
// types for the battery measurement and power mode controller
package bmm_pkg;
  typedef enum logic [1:0] {
    MODE_SAMPLE,
    MODE_RUN,
    MODE_SLEEP
  } bmm_mode_type;

  typedef enum logic [2:0] {
    PH_IDLE,
    PH_CUR,
    PH_VOLT,
    PH_TEMP,
    PH_CALC
  } bmm_phase_type;

  typedef struct packed {
    logic [15:0] zero_zone_limit;
    logic [15:0] current_offset_cal;
    logic [15:0] current_gain_cal;
    logic [15:0] voltage_offset_cal;
    logic [15:0] voltage_gain_cal;
    logic [15:0] int_temp_offset_cal;
    logic [15:0] int_temp_gain_cal;
    logic [15:0] ext_temp_offset_cal;
    logic [15:0] ext_temp_gain_cal;
    logic [15:0] path_resistance;
    logic [15:0] run_threshold_raw;
    logic [7:0]  sample_period_count;
    logic [15:0] sleep_voltage_limit;
    logic        autozero_en;
    logic        ext_temp_sel;
  } bmm_param_type;

  typedef struct packed {
    logic signed [15:0] current_ma;
    logic               current_valid;
    logic [15:0]        voltage_mv;
    logic signed [15:0] temp_val;
  } bmm_result_type;
endpackage

// file: verif/bmm_conv_model.sv
// behavioural converter front end answering conversion requests
`timescale 1ns/10ps
module bmm_conv_model (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        srst,
  // request from controller
  input  wire logic        conv_req,
  input  wire logic [1:0]  conv_chan,
  input  wire logic        sense_short,
  // values set by the bench
  input  wire logic [7:0]  ack_delay,
  input  wire logic [15:0] cur_raw,
  input  wire logic [15:0] volt_raw,
  input  wire logic [15:0] temp_raw,
  input  wire logic [15:0] zero_raw,
  // answer
  output logic             conv_ack,
  output logic [15:0]      conv_data
);
  logic [7:0] wait_ff;

  always_ff @(posedge sys_clk) begin
    conv_ack  <= 1'b0;
    conv_data <= ~conv_data;
    if (srst) begin
      wait_ff   <= 8'h00;
      conv_data <= 16'h5a5a;
    end else if (!conv_req || conv_ack) begin
      wait_ff <= 8'h00;
    end else if (wait_ff < ack_delay) begin
      wait_ff <= wait_ff + 8'h01;
    end else begin
      conv_ack <= 1'b1;
      if (sense_short) begin
        conv_data <= zero_raw;
      end else begin
        case (conv_chan)
          2'h0:    conv_data <= cur_raw;
          2'h1:    conv_data <= volt_raw;
          default: conv_data <= temp_raw;
        endcase
      end
    end
  end
endmodule

// file: verif/testbench.sv
// self-checking bench for the measurement and power mode controller
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin samples_checked++; if ((got) !== (exp)) begin fails++; \
  $display("CHECK FAILED %s exp %h got %h", nm, exp, got); end end
module testbench;
  logic                   sys_clk, srst, period_tick, wake_cfg_we, conv_ack, conv_req;
  logic                   io_activity, bus_activity, wake_current_hit, wake_voltage_hit;
  logic                   led_display_active, sense_short, therm_ref_en, calc_strobe;
  logic                   eoc_temp_en, bus_accept, display_en;
  logic [7:0]             wake_cfg_wdata, wake_source_config, ack_delay;
  logic [2:0]             wake_voltage_select;
  logic [1:0]             conv_chan;
  logic [15:0]            conv_data, cur_raw, volt_raw, temp_raw, zero_raw;
  bmm_pkg::bmm_param_type prm;
  bmm_pkg::bmm_result_type res;
  bmm_pkg::bmm_mode_type  mode;
  logic [3:0]             chans[$];
  int                     fails, samples_checked, cycles;

  bmm_ctrl #(.AZ_PERIODS(3)) DUT (
    .sys_clk(sys_clk), .srst(srst), .period_tick(period_tick), .prm(prm),
    .wake_cfg_we(wake_cfg_we), .wake_cfg_wdata(wake_cfg_wdata),
    .wake_source_config(wake_source_config), .conv_req(conv_req), .conv_chan(conv_chan),
    .sense_short(sense_short), .conv_ack(conv_ack), .conv_data(conv_data),
    .therm_ref_en(therm_ref_en), .io_activity(io_activity), .bus_activity(bus_activity),
    .wake_current_hit(wake_current_hit), .wake_voltage_hit(wake_voltage_hit),
    .led_display_active(led_display_active), .res(res), .mode(mode),
    .calc_strobe(calc_strobe), .eoc_temp_en(eoc_temp_en), .bus_accept(bus_accept),
    .display_en(display_en), .wake_voltage_select(wake_voltage_select));

  bmm_conv_model u_conv (
    .sys_clk(sys_clk), .srst(srst), .conv_req(conv_req), .conv_chan(conv_chan),
    .sense_short(sense_short), .ack_delay(ack_delay), .cur_raw(cur_raw),
    .volt_raw(volt_raw), .temp_raw(temp_raw), .zero_raw(zero_raw),
    .conv_ack(conv_ack), .conv_data(conv_data));

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // records {thermistor ref, short, channel} of every answered conversion
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (conv_ack === 1'b1) begin
      chans.push_back({therm_ref_en, sense_short, conv_chan});
    end
    if (cycles == 20000) begin
      fails++;
      end_of_test();
    end
  end

  // one measurement period, returns number of conversions answered
  task automatic tick_period(input logic [15:0] cur, output int n);
    int k;
    chans.delete();
    @(posedge sys_clk);
    period_tick <= 1'b1;
    cur_raw     <= cur;
    @(posedge sys_clk);
    period_tick <= 1'b0;
    for (k = 0; k < 400 && calc_strobe !== 1'b1; k++) @(negedge sys_clk);
    `CHK("calc_strobe", 1'b1, calc_strobe)
    @(negedge sys_clk);
    n = chans.size();
  endtask

  task automatic write_cfg(input logic [7:0] v);
    @(posedge sys_clk);
    wake_cfg_we    <= 1'b1;
    wake_cfg_wdata <= v;
    @(posedge sys_clk);
    wake_cfg_we <= 1'b0;
    @(negedge sys_clk);
    `CHK("wake_source_config", v, wake_source_config)
    `CHK("wake_voltage_select", v[2:0], wake_voltage_select)
  endtask

  initial begin
    int n;
    int i;
    int k;
    logic [15:0] prev;
    logic busy_seen;
    cycles = 0;
    fails = 0;
    samples_checked = 0;
    srst = 1'b1;
    period_tick = 1'b0;
    wake_cfg_we = 1'b0;
    wake_cfg_wdata = 8'h00;
    {io_activity, bus_activity, wake_current_hit, wake_voltage_hit} = 4'h0;
    led_display_active = 1'b0;
    ack_delay = 8'h02;
    cur_raw = 16'h0210;
    volt_raw = 16'h0fa0;
    temp_raw = 16'h0400;
    zero_raw = 16'h0020;
    prm = '0;
    prm.zero_zone_limit = 16'h0003;
    prm.current_offset_cal = 16'h0010;
    prm.current_gain_cal = 16'h2000;
    prm.voltage_offset_cal = 16'h0020;
    prm.voltage_gain_cal = 16'h0c00;
    prm.int_temp_gain_cal = 16'h0800;
    prm.int_temp_offset_cal = 16'h0010;
    prm.ext_temp_gain_cal = 16'h0800;
    prm.path_resistance = 16'h8000;
    prm.run_threshold_raw = 16'h0100;
    prm.sample_period_count = 8'h02;
    prm.ext_temp_sel = 1'b1;
    repeat (8) @(posedge sys_clk);
    srst <= 1'b0;
    @(negedge sys_clk);
    `CHK("mode", bmm_pkg::MODE_SAMPLE, mode)
    `CHK("conv_req", 1'b0, conv_req)
    `CHK("res", 1'b1, res == '0)
    `CHK("cfg", 8'h00, wake_source_config)
    `CHK("calc_strobe", 1'b0, calc_strobe)
    write_cfg(8'h7d);
    // first sample period converts current, voltage and external temperature
    tick_period(16'h0210, n);
    `CHK("acks", 3, n)
    `CHK("order", 12'h01b, {chans[0], chans[1], chans[2]})
    `CHK("current_ma", 16'h0100, res.current_ma)
    `CHK("current_valid", 1'b1, res.current_valid)
    `CHK("voltage_mv", 16'h17c0, res.voltage_mv)
    `CHK("mode", bmm_pkg::MODE_SAMPLE, mode)
    tick_period(16'h0210, n);
    `CHK("idle_acks", 0, n)
    tick_period(16'h0210, n);
    `CHK("acks", 3, n)
    `CHK("mode", bmm_pkg::MODE_RUN, mode)
    // run mode: qualification restarts after a failed comparison
    @(posedge sys_clk);
    prm.ext_temp_sel <= 1'b0;
    ack_delay <= 8'h14;
    tick_period(16'h0030, n);
    `CHK("run_acks", 3, n)
    `CHK("int_temp", 4'h2, chans[2])
    `CHK("int_temp_val", 16'h03f0, res.temp_val)
    `CHK("mode", bmm_pkg::MODE_RUN, mode)
    ack_delay <= 8'h02;
    tick_period(16'h0210, n);
    tick_period(16'h0030, n);
    `CHK("mode", bmm_pkg::MODE_RUN, mode)
    `CHK("bus_accept", 1'b1, bus_accept)
    `CHK("display_en", 1'b1, display_en)
    @(posedge sys_clk);
    led_display_active <= 1'b1;
    @(negedge sys_clk);
    `CHK("eoc_temp_en", 1'b0, eoc_temp_en)
    @(posedge sys_clk);
    led_display_active <= 1'b0;
    @(negedge sys_clk);
    `CHK("eoc_temp_en", 1'b1, eoc_temp_en)
    @(posedge sys_clk);
    prm.sleep_voltage_limit <= 16'h2000;
    tick_period(16'h0014, n);
    `CHK("zero_zone_ma", 16'h0000, res.current_ma)
    `CHK("zero_zone_valid", 1'b0, res.current_valid)
    `CHK("mode", bmm_pkg::MODE_SAMPLE, mode)
    for (i = 0; i < 3 && mode !== bmm_pkg::MODE_SLEEP; i++) tick_period(16'h0014, n);
    `CHK("mode", bmm_pkg::MODE_SLEEP, mode)
    // asleep: ticks start nothing
    busy_seen = 1'b0;
    @(posedge sys_clk);
    period_tick <= 1'b1;
    @(posedge sys_clk);
    period_tick <= 1'b0;
    repeat (60) begin
      @(negedge sys_clk);
      busy_seen = busy_seen | conv_req | calc_strobe;
    end
    `CHK("sleep_activity", 1'b0, busy_seen)
    `CHK("bus_accept", 1'b0, bus_accept)
    `CHK("display_en", 1'b0, display_en)
    write_cfg(8'h20);
    @(posedge sys_clk);
    {io_activity, wake_current_hit, wake_voltage_hit} <= 3'h7;
    repeat (10) @(posedge sys_clk);
    {io_activity, wake_current_hit, wake_voltage_hit} <= 3'h0;
    @(negedge sys_clk);
    `CHK("mode", bmm_pkg::MODE_SLEEP, mode)
    @(posedge sys_clk);
    bus_activity <= 1'b1;
    @(posedge sys_clk);
    bus_activity <= 1'b0;
    @(negedge sys_clk);
    `CHK("mode", bmm_pkg::MODE_RUN, mode)
    // auto-zero replaces one current conversion
    @(posedge sys_clk);
    prm.autozero_en <= 1'b1;
    n = 0;
    for (i = 0; i < 8 && !(chans.size() > 0 && chans[0][2] === 1'b1); i++) begin
      prev = res.current_ma;
      tick_period(16'h0210, n);
    end
    `CHK("autozero_seen", 1'b1, chans.size() > 0 && chans[0][2] === 1'b1)
    `CHK("current_reused", prev, res.current_ma)
    tick_period(16'h0210, n);
    `CHK("current_after_zero", 16'h00f0, res.current_ma)
    // io, current and voltage wake, each from a fresh sleep entry
    for (i = 0; i < 3; i++) begin
      for (k = 0; k < 4 && mode !== bmm_pkg::MODE_SLEEP; k++) tick_period(16'h0014, n);
      `CHK("mode", bmm_pkg::MODE_SLEEP, mode)
      write_cfg(i == 0 ? 8'h40 : 8'h20 >> i);
      @(posedge sys_clk);
      {io_activity, wake_current_hit, wake_voltage_hit} <= 3'h4 >> i;
      @(posedge sys_clk);
      {io_activity, wake_current_hit, wake_voltage_hit} <= 3'h0;
      @(negedge sys_clk);
      `CHK("mode", bmm_pkg::MODE_RUN, mode)
    end
    end_of_test();
  end
endmodule
